// ### dv/dds_core_asserts.sv
// port assertions for the dds core
`timescale 1ns/100ps
module dds_core_asserts (
    input wire        sys_clk,
    input wire        srst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    input wire        commit_pin,
    input wire        pll_bypass,
    input wire [13:0] dac_sample,
    input wire        dac_valid,
    input wire        dac_ready
);
    // ----
    // properties
    // ----
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    wire setup   = psel && !penable;
    wire wr_ctrl = psel && penable && pwrite && paddr == 12'h000;
    ready_high_a: assert property (pready) else $error("pready low");
    reset_clear_a: assert property ($fell(srst) |-> !dac_valid && !pslverr
        && prdata == 32'h0 && !pll_bypass) else $error("outputs not cleared");
    read_hold_a: assert property (!setup |=> $stable(prdata) && $stable(pslverr))
        else $error("read data moved");
    bad_addr_a: assert property (setup && paddr > 12'h020 |=> pslverr
        && prdata == 32'h0) else $error("hole not refused");
    good_addr_a: assert property (setup && paddr <= 12'h020
        && paddr[1:0] == 2'h0 |=> !pslverr) else $error("mapped refused");
    run_start_a: assert property (wr_ctrl && pwdata[0] && !dac_valid
        |-> ##2 dac_valid) else $error("no sample after run");
    bypass_wr_a: assert property (wr_ctrl |=> pll_bypass == $past(pwdata[1]))
        else $error("bypass not written");
    stall_hold_a: assert property (dac_valid && !dac_ready
        |=> dac_valid && $stable(dac_sample)) else $error("sample lost");
endmodule // dds_core_asserts

bind dds_core dds_core_asserts u_chk (.sys_clk(sys_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .commit_pin(commit_pin),
    .pll_bypass(pll_bypass), .dac_sample(dac_sample), .dac_valid(dac_valid),
    .dac_ready(dac_ready));

// ### dv/dds_dac_sink.sv
// dac side sink model with selectable readiness
`timescale 1ns/100ps
module dds_dac_sink (
    input wire       sys_clk,
    input wire       srst,
    input wire [1:0] mode,
    output reg       dac_ready = 1'b0
);
    integer seed = 79016;
    // 0 ready, 2 random, else stalled; random readiness shakes the buffer
    always @(posedge sys_clk)
    begin
        if (srst)
            dac_ready <= 1'b0;
        else
            dac_ready <= (mode == 2'h0) || (mode == 2'h2 && $random(seed) & 1);
    end
endmodule // dds_dac_sink

// ### dv/tb.sv
// self-checking bench for the dds core
`timescale 1ns/100ps
`include "dds_map.vh"
module tb;
    reg         sys_clk = 1'b0;
    reg         srst = 1'b1;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg         commit_pin = 1'b0;
    reg  [1:0]  mode = 2'h0;
    wire        pready;
    wire [31:0] prdata;
    wire        pslverr;
    wire        pll_bypass;
    wire [13:0] dac_sample;
    wire        dac_valid;
    wire        dac_ready;
    reg  [47:0] acc_exp = 48'h0;
    reg  [47:0] step = 48'h0;
    reg  [47:0] stage;
    reg  [13:0] ph = 14'h0;
    reg  [13:0] ph_new;
    reg  [31:0] rd;
    reg         err;
    integer     fail_count = 0;
    integer     comparisons = 0;
    integer     seed = 79016;
    integer     cycles = 0;
    integer     k = 0;
    integer     n;

    always #25 sys_clk = ~sys_clk;

    dds_core DUT (.sys_clk(sys_clk), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .commit_pin(commit_pin),
        .pll_bypass(pll_bypass), .dac_sample(dac_sample), .dac_valid(dac_valid),
        .dac_ready(dac_ready));
    dds_dac_sink u_sink (.sys_clk(sys_clk), .srst(srst), .mode(mode),
        .dac_ready(dac_ready));

    // ----
    // expectations and bus tasks
    // ----
    function [47:0] step_used();
        case (k)
            4: step_used = `DDS_PROF0;
            5: step_used = `DDS_PROF1;
            6: step_used = `DDS_PROF2;
            7: step_used = `DDS_PROF3;
            default: step_used = step;
        endcase
    endfunction

    function [13:0] sine(input [47:0] a, input [13:0] p);
        reg [13:0] q;
        reg [31:0] h;
        reg [31:0] m;
        begin
            q = a[47:34] + p;
            h = {19'h0, q[12:0]};
            m = (h * (32'h2000 - h)) >> 11;
            if (m > 32'h1FFF)
                m = 32'h1FFF;
            sine = q[13] ? 14'h2000 - m[13:0] : 14'h2000 + m[13:0];
        end
    endfunction

    task check(input string name, input [63:0] seen, input [63:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp)
            begin
                fail_count = fail_count + 1;
                $display("ERROR %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    task print_verdict;
        begin
            if (fail_count == 0 && comparisons > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // one apb transfer; the request stands until pready is seen high
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge sys_clk);
            penable <= 1'b1;
            @(posedge sys_clk);
            while (pready !== 1'b1)
                @(posedge sys_clk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge sys_clk);
        end
    endtask

    task rchk(input string name, input [11:0] a, input [31:0] exp);
        begin
            apb(1'b0, a, 32'h0);
            check(name, rd, exp);
        end
    endtask

    always @(posedge sys_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 5000)
        begin
            fail_count = fail_count + 1;
            print_verdict;
        end
    end

    // every consumed sample must follow the running phase total
    always @(posedge sys_clk)
    begin
        if (!srst && dac_valid && dac_ready)
        begin
            check("sample", dac_sample, sine(acc_exp, ph));
            acc_exp = acc_exp + step_used();
        end
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        @(posedge sys_clk);
        rchk("ctrl", `DDS_OFF_CTRL, 32'h0);
        check("okay", err, 1'b0);
        rchk("acc", `DDS_OFF_ACC, 32'h0);
        rchk("hole", 12'h100, 32'h0);
        check("slverr", err, 1'b1);
        for (k = 0; k < 8; k = k + 1)
        begin
            rd = $random(seed);
            // steps stay under 40 percent of the rate; first one sits on it
            stage = (k == 0) ? 48'h666666666666 : {2'h0, rd[27:14], $random(seed)};
            ph_new = (k == 0) ? 14'h3FFF : rd[13:0];
            apb(1'b1, `DDS_OFF_STEP_LO, stage[31:0]);
            apb(1'b1, `DDS_OFF_STEP_HI, {16'h0, stage[47:32]});
            apb(1'b1, `DDS_OFF_PHASE, {18'h0, ph_new});
            apb(1'b1, `DDS_OFF_ACT_LO, ~stage[31:0]);
            rchk("staged", `DDS_OFF_ACT_LO, step[31:0]);
            if (k[0])
            begin
                commit_pin <= 1'b1;
                repeat (4) @(posedge sys_clk);
                commit_pin <= 1'b0;
                @(posedge sys_clk);
            end
            else
            begin
                apb(1'b1, `DDS_OFF_COMMIT, 32'h1);
                apb(1'b1, `DDS_OFF_COMMIT, 32'h0);
            end
            step = stage;
            ph = ph_new;
            rchk("act_lo", `DDS_OFF_ACT_LO, step[31:0]);
            rchk("act_hi", `DDS_OFF_ACT_HI, {16'h0, step[47:32]});
            rchk("status", `DDS_OFF_STATUS, {2'h0, ph, 14'h0, 2'h2});
            mode <= k[1:0];
            apb(1'b1, `DDS_OFF_CTRL, {26'h0, k[1:0], 1'b0, k[2], k[0], 1'b1});
            check("bypass", pll_bypass, k[0]);
            repeat (30) @(posedge sys_clk);
            if (k[0])
                rchk("full", `DDS_OFF_STATUS, {2'h0, ph, 14'h0, 2'h1});
            mode <= 2'h0;
            apb(1'b1, `DDS_OFF_CTRL, 32'h0);
            for (n = 0; n < 8 && dac_valid !== 1'b0; n = n + 1)
                @(posedge sys_clk);
            check("drained", dac_valid, 1'b0);
            rchk("acc", `DDS_OFF_ACC, acc_exp[47:16]);
        end
        print_verdict;
    end
endmodule // tb

// ### verilog/dds_core.v
// dds core: phase accumulator, phase offset, sample stream and apb registers
`timescale 1ns/100ps
`include "dds_map.vh"


module dds_core (
    input  wire        sys_clk,
    input  wire        srst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output reg         pslverr,
    input  wire        commit_pin,
    output wire        pll_bypass,
    output wire [13:0] dac_sample,
    output wire        dac_valid,
    input  wire        dac_ready
);

// ----------------------------------------
// declarations
// ----------------------------------------
reg  [5:0]  ctrl;
reg  [47:0] step_stage;
reg  [13:0] phase_stage;
reg         commit_lvl;
reg         commit_lvl_d;
reg  [47:0] step_act;
reg  [13:0] phase_act;
reg  [47:0] acc;
reg         pin_meta;
reg         pin_sync;
reg         pin_sync_d;
reg  [47:0] preset_step;
reg  [47:0] step_eff;
reg  [31:0] next_prdata;
reg         next_pslverr;
wire        setup;
wire        wr_access;
wire        commit;
wire        run;
wire [1:0]  prof_sel;
wire [13:0] phase_sum;
wire [13:0] sample;
wire        buf_ready;
wire        advance;

// ----------------------------------------
// apb slave
// ----------------------------------------
// zero wait states: read data is captured in the setup cycle so it
// comes from a flip-flop during the access phase
assign pready    = 1'b1;
assign setup     = psel & ~penable;
assign wr_access = psel & penable & pwrite;

always @*
begin
    next_prdata  = 32'h00000000;
    next_pslverr = 1'b0;
    case (paddr)
        `DDS_OFF_CTRL:
            next_prdata = {26'h0000000, ctrl};
        `DDS_OFF_STEP_LO:
            next_prdata = step_stage[31:0];
        `DDS_OFF_STEP_HI:
            next_prdata = {16'h0000, step_stage[47:32]};
        `DDS_OFF_PHASE:
            next_prdata = {18'h00000, phase_stage};
        `DDS_OFF_COMMIT:
            next_prdata = {31'h00000000, commit_lvl};
        `DDS_OFF_ACT_LO:
            next_prdata = step_act[31:0];
        `DDS_OFF_ACT_HI:
            next_prdata = {16'h0000, step_act[47:32]};
        `DDS_OFF_STATUS:
        begin
            next_prdata[`DDS_STAT_OVALID] = dac_valid;
            next_prdata[`DDS_STAT_IREADY] = buf_ready;
            next_prdata[`DDS_STAT_PH_MSB:`DDS_STAT_PH_LSB] = phase_act;
        end
        `DDS_OFF_ACC:
            next_prdata = acc[47:16];
        default:
            next_pslverr = 1'b1;
    endcase
end

always @(posedge sys_clk)
begin
    if (srst)
    begin
        prdata  <= `DDS_RDATA_RST;
        pslverr <= 1'b0;
    end
    else if (setup)
    begin
        prdata  <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= next_pslverr;
    end
end

// ----------------------------------------
// control word, commit bit and staged settings written by software
// ----------------------------------------
always @(posedge sys_clk)
begin
    if (srst)
    begin
        ctrl        <= `DDS_CTRL_RST;
        step_stage  <= `DDS_STEP_RST;
        phase_stage <= `DDS_PHASE_RST;
        commit_lvl  <= 1'b0;
    end
    else if (wr_access)
    begin
        case (paddr)
            `DDS_OFF_CTRL:
                ctrl <= pwdata[5:0];
            `DDS_OFF_STEP_LO:
                step_stage[31:0] <= pwdata;
            `DDS_OFF_STEP_HI:
                step_stage[47:32] <= pwdata[15:0];
            `DDS_OFF_PHASE:
                phase_stage <= pwdata[13:0];
            `DDS_OFF_COMMIT:
                commit_lvl <= pwdata[0];
            default:
                commit_lvl <= commit_lvl;
        endcase
    end
end

assign run        = ctrl[`DDS_CTRL_RUN];
assign pll_bypass = ctrl[`DDS_CTRL_BYPASS];
assign prof_sel   = ctrl[`DDS_CTRL_PROF_MSB:`DDS_CTRL_PROF_LSB];

// ----------------------------------------
// commit strobe: pin and software bit
// ----------------------------------------
// the pin is asynchronous to the sample clock, so it is synchronised
// before its edge is taken
always @(posedge sys_clk)
begin
    if (srst)
    begin
        pin_meta     <= 1'b0;
        pin_sync     <= 1'b0;
        pin_sync_d   <= 1'b0;
        commit_lvl_d <= 1'b0;
    end
    else
    begin
        pin_meta     <= commit_pin;
        pin_sync     <= pin_meta;
        pin_sync_d   <= pin_sync;
        commit_lvl_d <= commit_lvl;
    end
end

// only a low-to-high transition commits; holding the strobe high does not
assign commit = (pin_sync & ~pin_sync_d) | (commit_lvl & ~commit_lvl_d);

always @(posedge sys_clk)
begin
    if (srst)
    begin
        step_act  <= `DDS_STEP_RST;
        phase_act <= `DDS_PHASE_RST;
    end
    else if (commit)
    begin
        step_act  <= step_stage;
        phase_act <= phase_stage;
    end
end

// ----------------------------------------
// preset profiles
// ----------------------------------------
// a preset runs without any step word having been written
always @*
begin
    case (prof_sel)
        2'd0:
            preset_step = `DDS_PROF0;
        2'd1:
            preset_step = `DDS_PROF1;
        2'd2:
            preset_step = `DDS_PROF2;
        2'd3:
            preset_step = `DDS_PROF3;
        default:
            preset_step = `DDS_PROF0;
    endcase
end

always @*
begin
    if (ctrl[`DDS_CTRL_PROF_EN])
        step_eff = preset_step;
    else
        step_eff = step_act;
end

// ----------------------------------------
// phase accumulator
// ----------------------------------------
// runs on sys_clk, the sample clock; a full buffer stalls it so no
// sample is lost and no phase step is skipped, at the cost of a pause in the sample stream
assign advance = run & buf_ready;

always @(posedge sys_clk)
begin
    if (srst)
        acc <= `DDS_ACC_RST;
    else if (advance)
        acc <= acc + step_eff;
end

// ----------------------------------------
// phase offset and sample generation
// ----------------------------------------
// top bits of the phase only: lower bits add resolution in frequency,
// not in the sample, hence the truncation spurs
assign phase_sum = acc[47:34] + phase_act;

dds_sine u_sine (
    .phase  (phase_sum),
    .sample (sample)
);

// ----------------------------------------
// sample buffer towards the dac
// ----------------------------------------
dds_fifo2 #(
    .WIDTH (`DDS_SMP_W)
) u_buf (
    .sys_clk   (sys_clk),
    .srst      (srst),
    .in_data   (sample),
    .in_valid  (run),
    .in_ready  (buf_ready),
    .out_data  (dac_sample),
    .out_valid (dac_valid),
    .out_ready (dac_ready)
);

endmodule // dds_core

// ### verilog/dds_fifo2.v
// two-entry sample buffer with valid and ready on both sides
`timescale 1ns/100ps

module dds_fifo2 #(
    parameter WIDTH = 14
) (
    input  wire             sys_clk,
    input  wire             srst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output wire             in_ready,
    output wire [WIDTH-1:0] out_data,
    output wire             out_valid,
    input  wire             out_ready
);

// ----------------------------------------
// storage and pointers
// ----------------------------------------
reg [WIDTH-1:0] mem [0:1];
reg             wr_ptr;
reg             rd_ptr;
reg [1:0]       count;
wire            push;
wire            pop;

assign in_ready  = (count != 2'd2);
assign out_valid = (count != 2'd0);
assign out_data  = mem[rd_ptr];
assign push      = in_valid & in_ready;
assign pop       = out_valid & out_ready;

always @(posedge sys_clk)
begin
    if (srst)
    begin
        wr_ptr <= 1'b0;
        rd_ptr <= 1'b0;
        count  <= 2'd0;
    end
    else
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
            wr_ptr      <= ~wr_ptr;
        end
        if (pop)
            rd_ptr <= ~rd_ptr;
        if (push & ~pop)
            count <= count + 2'd1;
        else if (pop & ~push)
            count <= count - 2'd1;
    end
end

endmodule // dds_fifo2

// ### verilog/dds_map.vh
// register map, field positions, reset values and profile table of the dds core
`ifndef DDS_MAP_VH
`define DDS_MAP_VH

// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define DDS_OFF_CTRL       12'h000
`define DDS_OFF_STEP_LO    12'h004
`define DDS_OFF_STEP_HI    12'h008
`define DDS_OFF_PHASE      12'h00C
`define DDS_OFF_COMMIT     12'h010
`define DDS_OFF_ACT_LO     12'h014
`define DDS_OFF_ACT_HI     12'h018
`define DDS_OFF_STATUS     12'h01C
`define DDS_OFF_ACC        12'h020

// ----------------------------------------
// field positions
// ----------------------------------------
`define DDS_CTRL_RUN       0
`define DDS_CTRL_BYPASS    1
`define DDS_CTRL_PROF_EN   2
`define DDS_CTRL_PROF_LSB  4
`define DDS_CTRL_PROF_MSB  5
`define DDS_STAT_OVALID    0
`define DDS_STAT_IREADY    1
`define DDS_STAT_PH_LSB    16
`define DDS_STAT_PH_MSB    29

// ----------------------------------------
// widths and reset values
// ----------------------------------------
`define DDS_ACC_W          48
`define DDS_PH_W           14
`define DDS_SMP_W          14
`define DDS_CTRL_RST       6'h00
`define DDS_STEP_RST       48'h000000000000
`define DDS_PHASE_RST      14'h0000
`define DDS_ACC_RST        48'h000000000000
`define DDS_RDATA_RST      32'h00000000

// ----------------------------------------
// preset step words: fs/16, fs/8, fs/5 (approx), fs/4
// ----------------------------------------
`define DDS_PROF0          48'h100000000000
`define DDS_PROF1          48'h200000000000
`define DDS_PROF2          48'h333333333333
`define DDS_PROF3          48'h400000000000

`endif

// ### verilog/dds_sine.v
// phase to sine sample converter feeding the dac
`timescale 1ns/100ps

module dds_sine (
    input  wire [13:0] phase,
    output wire [13:0] sample
);

// ----------------------------------------
// parabolic half-wave shaper
// ----------------------------------------
// 4p(1-p) per half period: a few percent of shape error traded for
// no table storage and no extra pipeline stage
wire [12:0] half_pos;
wire [13:0] half_rem;
wire [27:0] prod;
wire [13:0] mag_raw;
wire [12:0] mag;

assign half_pos = phase[12:0];
assign half_rem = 14'h2000 - {1'b0, half_pos};
assign prod     = {15'h0000, half_pos} * {14'h0000, half_rem};
assign mag_raw  = prod[24:11];
assign mag      = mag_raw[13] ? 13'h1FFF : mag_raw[12:0];

// offset binary: mid scale is zero, top phase bit picks the half
assign sample = phase[13] ? (14'h2000 - {1'b0, mag}) : (14'h2000 + {1'b0, mag});

endmodule // dds_sine
